/* File: include/port_ctrl_pkg.sv */
// constants shared by the repeater port control register bank
package port_ctrl_pkg;
  // register addresses on the management register port
  localparam logic [7:0] ADDR_LINK_INTEGRITY = 8'h91;
  localparam logic [7:0] ADDR_PARTITION_SEL = 8'h94;
  localparam logic [7:0] ADDR_PORT_ENABLE = 8'h95;
  // port counts and field widths
  localparam int TP_PORTS = 4;
  localparam int ALL_PORTS = 5;
  localparam int CNT_W = 10;
  // values after reset
  localparam logic [3:0] LINK_EN_RST = 4'hf;
  localparam logic [4:0] PART_SEL_RST = 5'h1f;
  localparam logic [4:0] PORT_EN_RST = 5'h1f;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  // reconnect after this many clean bit times (least of the allowed span)
  localparam logic [9:0] RECOVER_BITS = 10'h1c2;
  // edges to wait after reset before the disable strap is trusted
  localparam logic [1:0] STRAP_SETTLE = 2'h2;
endpackage : port_ctrl_pkg

/* File: rtl/repeater_port_control_regs.sv */
// per-port link, partition recovery and enable control of the repeater
`timescale 1ns/1ps
`default_nettype none
module repeater_port_control_regs
  import port_ctrl_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  // management register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  // power-up disable strap pin, asynchronous
  input wire logic hw_disable_n,
  // repeater core status, same clock
  input wire logic [3:0] link_fail,
  input wire logic [4:0] port_speed_100,
  input wire logic [4:0] port_partitioned,
  input wire logic [4:0] port_rx_act,
  input wire logic [4:0] port_tx_act,
  input wire logic [4:0] port_collision,
  input wire logic tick_10m,
  input wire logic tick_100m,
  // controls to the repeater core
  output logic [3:0] link_disconnect,
  output logic [4:0] alt_partition,
  output logic [4:0] port_enable,
  output logic [4:0] port_reconnect
);

  // whole state of the block in one record
  typedef struct packed {
    logic strap_s1;                       // first synchroniser stage
    logic strap_s2;                       // second synchroniser stage
    logic [1:0] strap_cnt;                // settle counter after reset
    logic strap_done;                     // strap sampled once
    logic [3:0] link_en;                  // link integrity enables
    logic [4:0] alt_sel;                  // partition algorithm select
    logic [4:0] port_en;                  // port enables
    logic [4:0][CNT_W-1:0] clean_cnt;     // clean bit times per port
    logic [3:0] disc;                     // link fail disconnect
    logic [4:0] reconn;                   // reconnect pulses
    logic [31:0] rdata;                   // read data
    logic rvalid;                         // read answer strobe
  } state_s;

  state_s state_ff;
  state_s nxt_state;
  logic [4:0] qualify;   // per-port qualifying activity
  logic [4:0] bit_tick;  // per-port bit time strobe
  logic i_unused;

  // next state of every field
  always_comb begin
    nxt_state = state_ff;
    qualify = 5'h00;
    bit_tick = 5'h00;
    nxt_state.reconn = 5'h00;
    nxt_state.rvalid = 1'b0;
    // pin passes two flops before use
    nxt_state.strap_s1 = hw_disable_n;
    nxt_state.strap_s2 = state_ff.strap_s1;
    // let the synchroniser fill with the real pin level first
    if (!state_ff.strap_done) begin
      if (state_ff.strap_cnt == STRAP_SETTLE) begin
        nxt_state.strap_done = 1'b1;
        if (!state_ff.strap_s2) begin
          nxt_state.port_en = 5'h00;
        end
      end else begin
        nxt_state.strap_cnt = state_ff.strap_cnt + 2'h1;
      end
    end
    // software writes; they follow the strap so a later write restores ports
    if (reg_wr) begin
      case (reg_addr)
        ADDR_LINK_INTEGRITY: begin
          nxt_state.link_en = reg_wdata[3:0];
        end
        ADDR_PARTITION_SEL: begin
          nxt_state.alt_sel = reg_wdata[4:0];
        end
        ADDR_PORT_ENABLE: begin
          nxt_state.port_en = reg_wdata[4:0];
        end
        // unmapped or other blocks: nothing stored
        default: begin
          nxt_state.link_en = state_ff.link_en;
        end
      endcase
    end
    // reads answer one cycle later
    if (reg_rd) begin
      nxt_state.rvalid = 1'b1;
      case (reg_addr)
        ADDR_LINK_INTEGRITY: begin
          nxt_state.rdata = {28'h000_0000, state_ff.link_en};
        end
        ADDR_PARTITION_SEL: begin
          nxt_state.rdata = {27'h000_0000, state_ff.alt_sel};
        end
        ADDR_PORT_ENABLE: begin
          nxt_state.rdata = {27'h000_0000, state_ff.port_en};
        end
        // unmapped reads return zero
        default: begin
          nxt_state.rdata = RDATA_RST;
        end
      endcase
    end
    nxt_state.disc = state_ff.link_en & link_fail;
    // per-port recovery timing
    for (int i = 0; i < ALL_PORTS; i++) begin
      bit_tick[i] = port_speed_100[i] ? tick_100m : tick_10m;
      if (port_speed_100[i] == state_ff.alt_sel[i]) begin
        qualify[i] = port_rx_act[i] | port_tx_act[i];
      end else begin
        qualify[i] = port_tx_act[i];
      end
      // a collision or a gap restarts the clean window
      if (port_collision[i] || !qualify[i] || !port_partitioned[i]) begin
        nxt_state.clean_cnt[i] = 10'h000;
      end else if (bit_tick[i]) begin
        if (state_ff.clean_cnt[i] == RECOVER_BITS - 10'h001) begin
          // window complete; restart so only one pulse per span
          nxt_state.reconn[i] = 1'b1;
          nxt_state.clean_cnt[i] = 10'h000;
        end else begin
          nxt_state.clean_cnt[i] = state_ff.clean_cnt[i] + 10'h001;
        end
      end
    end
  end

  // upper write data bits are reserved and deliberately ignored
  assign i_unused = |reg_wdata[31:5];

  // state register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff.strap_s1 <= 1'b1;
      state_ff.strap_s2 <= 1'b1;
      state_ff.strap_cnt <= 2'h0;
      state_ff.strap_done <= 1'b0;
      state_ff.link_en <= LINK_EN_RST;
      state_ff.alt_sel <= PART_SEL_RST;
      state_ff.port_en <= PORT_EN_RST;
      state_ff.clean_cnt <= '0;
      state_ff.disc <= 4'h0;
      state_ff.reconn <= 5'h00;
      state_ff.rdata <= RDATA_RST;
      state_ff.rvalid <= 1'b0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // outputs straight from the state flops
  assign reg_rdata = state_ff.rdata;
  assign reg_rvalid = state_ff.rvalid;
  assign link_disconnect = state_ff.disc;
  assign alt_partition = state_ff.alt_sel;
  assign port_enable = state_ff.port_en;
  assign port_reconnect = state_ff.reconn;

  link_read_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_rd && reg_addr == ADDR_LINK_INTEGRITY |=> reg_rvalid && reg_rdata[31:4] == 28'h000_0000)
    else $error("link register reserved bits not zero");

  no_disc_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (link_disconnect & ~$past(state_ff.link_en)) == 4'h0)
    else $error("disconnect while link integrity disabled");

  disc_on_fail_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_ff.link_en & link_fail) == 4'hf |=> link_disconnect == 4'hf)
    else $error("enabled port not disconnected on link fail");

  gen_read_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_rd && (reg_addr == ADDR_PARTITION_SEL || reg_addr == ADDR_PORT_ENABLE)
    |=> reg_rdata[31:5] == 27'h000_0000)
    else $error("general register reserved bits not zero");

  sel_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_wr && reg_addr == ADDR_PARTITION_SEL |=> alt_partition == $past(reg_wdata[4:0]))
    else $error("partition select not taken");

  no_col_recon_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (port_reconnect & $past(port_collision)) == 5'h00)
    else $error("reconnect despite collision");

  strict_tx_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (port_reconnect & ~($past(port_speed_100) ^ ~$past(state_ff.alt_sel))
      & ~$past(port_tx_act)) == 5'h00)
    else $error("strict recovery without transmit");

  en_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_wr && reg_addr == ADDR_PORT_ENABLE |=> port_enable == $past(reg_wdata[4:0]))
    else $error("port enable not taken");

  strap_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !state_ff.strap_done && state_ff.strap_cnt == STRAP_SETTLE && !state_ff.strap_s2 && !reg_wr
    |=> port_enable == 5'h00)
    else $error("strap low did not disable ports");

  unmapped_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_rd && reg_addr != ADDR_LINK_INTEGRITY && reg_addr != ADDR_PARTITION_SEL
      && reg_addr != ADDR_PORT_ENABLE |=> reg_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  // answer strobe only after a read
  rvalid_after_rd_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_rvalid |-> $past(reg_rd))
    else $error("read answer without a read request");

  link_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_wr && reg_addr == ADDR_LINK_INTEGRITY |=> state_ff.link_en == $past(reg_wdata[3:0]))
    else $error("link integrity write not taken");

  // disconnect tracks enabled fail one cycle late
  disc_follow_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    link_disconnect == $past(state_ff.link_en & link_fail))
    else $error("disconnect does not follow enabled link fail");

  sel_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_rd && reg_addr == ADDR_PARTITION_SEL |=> reg_rdata[4:0] == $past(state_ff.alt_sel))
    else $error("partition select readback wrong");

  en_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_rd && reg_addr == ADDR_PORT_ENABLE |=> reg_rdata[4:0] == $past(state_ff.port_en))
    else $error("port enable readback wrong");

  // unmapped writes leave every control alone
  // strap capture may still move the enables, so only look once it is done
  unmapped_wr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_wr && state_ff.strap_done && reg_addr != ADDR_LINK_INTEGRITY
      && reg_addr != ADDR_PARTITION_SEL && reg_addr != ADDR_PORT_ENABLE
    |=> $stable(port_enable) && $stable(alt_partition) && $stable(state_ff.link_en))
    else $error("unmapped write changed a control");

  // reconnect only for a partitioned port
  recon_part_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (port_reconnect & ~$past(port_partitioned)) == 5'h00)
    else $error("reconnect for a port that was not partitioned");

  // strap is sampled once and never again
  // a second capture would undo software re-enabling the ports
  strap_once_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_ff.strap_done |=> state_ff.strap_done)
    else $error("strap capture re-armed without reset");

  // reconnect needs a bit time strobe on the port's speed
  recon_tick_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (port_reconnect & ~($past(port_speed_100) & {5{$past(tick_100m)}})
      & ~(~$past(port_speed_100) & {5{$past(tick_10m)}})) == 5'h00)
    else $error("reconnect without a bit time strobe");

endmodule // repeater_port_control_regs
`default_nettype wire

/* File: test/testbench.sv */
// self-checking bench for the repeater port control register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import port_ctrl_pkg::*;
  logic core_clk, rst_n, reg_wr, reg_rd, reg_rvalid, hw_disable_n, tick_10m, tick_100m;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [3:0] link_fail, link_disconnect;
  logic [4:0] port_speed_100, port_partitioned, port_rx_act, port_tx_act, port_collision;
  logic [4:0] alt_partition, port_enable, port_reconnect;
  logic [4:0] seen_ff; // sticky record of reconnect pulses
  int miscompares = 0;
  int checked = 0;
  // rows: address, data written, value read back (reserved bits and unmapped give zero)
  logic [7:0] row_addr [4] = '{8'h91, 8'h94, 8'h95, 8'h33};
  logic [31:0] row_wdata [4] = '{32'hffff_fff5, 32'hffff_ffea, 32'h0000_0013, 32'hffff_ffff};
  logic [31:0] row_exp [4] = '{32'h0000_0005, 32'h0000_000a, 32'h0000_0013, 32'h0000_0000};

  repeater_port_control_regs uut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .hw_disable_n(hw_disable_n), .link_fail(link_fail),
    .port_speed_100(port_speed_100), .port_partitioned(port_partitioned),
    .port_rx_act(port_rx_act), .port_tx_act(port_tx_act), .port_collision(port_collision),
    .tick_10m(tick_10m), .tick_100m(tick_100m), .link_disconnect(link_disconnect),
    .alt_partition(alt_partition), .port_enable(port_enable), .port_reconnect(port_reconnect));

  // 125 mhz clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // collect one-cycle reconnect pulses so none is missed
  always @(posedge core_clk) begin
    seen_ff <= rst_n ? (seen_ff | port_reconnect) : 5'h00;
  end

  // compare and count
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // verdict and end of run
  task results;
    if (miscompares == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // reset held 10 cycles, strap pin steady across it
  task do_reset(input logic strap);
    hw_disable_n = strap;
    rst_n = 1'b0;
    repeat (10) @(posedge core_clk);
    #1 rst_n = 1'b1;
  endtask

  // one-cycle write strobe
  task wr(input logic [7:0] addr, input logic [31:0] data);
    reg_addr = addr;
    reg_wdata = data;
    reg_wr = 1'b1;
    @(posedge core_clk);
    #1 reg_wr = 1'b0;
  endtask

  // one-cycle read strobe; answer lands exactly one edge later
  task rd(input logic [7:0] addr, input logic [31:0] exp);
    reg_addr = addr;
    reg_rd = 1'b1;
    @(posedge core_clk);
    #1 reg_rd = 1'b0;
    check({31'h0000_0000, reg_rvalid}, 32'h0000_0001);
    check(reg_rdata, exp);
    // let an edge pass so a following read never re-raises the strobe in this step
    @(posedge core_clk);
    #1;
  endtask

  // bit-time strobes on both speeds, one every other cycle
  task tick_n(input int n);
    for (int i = 0; i < n; i++) begin
      tick_10m = 1'b1;
      tick_100m = 1'b1;
      @(posedge core_clk);
      #1 tick_10m = 1'b0;
      tick_100m = 1'b0;
      @(posedge core_clk);
      #1;
    end
  endtask

  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    results;
  end

  // main sequence
  initial begin
    {reg_wr, reg_rd, tick_10m, tick_100m} = 4'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    {link_fail, port_speed_100, port_partitioned} = 14'h0000;
    {port_rx_act, port_tx_act, port_collision} = 15'h0000;
    do_reset(1'b1);
    check(port_enable, PORT_EN_RST);
    check(alt_partition, PART_SEL_RST);
    rd(ADDR_LINK_INTEGRITY, {28'h000_0000, LINK_EN_RST});
    rd(ADDR_PARTITION_SEL, {27'h000_0000, PART_SEL_RST});
    rd(ADDR_PORT_ENABLE, {27'h000_0000, PORT_EN_RST});
    link_fail = 4'hf;
    @(posedge core_clk);
    #1 check(link_disconnect, 4'hf);
    link_fail = 4'h0;
    for (int r = 0; r < 4; r++) begin
      wr(row_addr[r], row_wdata[r]);
      rd(row_addr[r], row_exp[r]);
    end
    check(alt_partition, 5'h0a);
    check(port_enable, 5'h13);
    // ports 2 and 4 no longer disconnect on link fail
    link_fail = 4'hf;
    @(posedge core_clk);
    #1 check(link_disconnect, 4'h5);
    link_fail = 4'h0;
    // four speed/algorithm mixes on ports 1-4, port 5 held in collision
    port_speed_100 = 5'h0c;
    port_partitioned = 5'h1f;
    port_rx_act = 5'h0f;
    port_tx_act = 5'h10;
    port_collision = 5'h10;
    tick_n(449);
    check(seen_ff, 5'h00);
    tick_n(1);
    repeat (4) @(posedge core_clk);
    #1 check(seen_ff, 5'h09);
    port_partitioned = 5'h00;
    // strap low over reset keeps all ports off until software
    do_reset(1'b0);
    repeat (8) @(posedge core_clk);
    #1 check(port_enable, 5'h00);
    rd(ADDR_PORT_ENABLE, 32'h0000_0000);
    wr(ADDR_PORT_ENABLE, 32'h0000_001f);
    check(port_enable, 5'h1f);
    check(alt_partition, PART_SEL_RST);
    results;
  end
endmodule // testbench
`default_nettype wire
